// [hdl/tas_pkg.sv]
// constants and types of the triggered acquisition sequencer
package tas_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_P0   = 8'h04;
  localparam logic [7:0] A_P1   = 8'h08;
  localparam logic [7:0] A_P2   = 8'h0c;
  localparam logic [7:0] A_P3   = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_REM  = 8'h18;
  localparam logic [7:0] A_SCAN = 8'h1c;

  // ==========================================================
  // status and scan field positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_TBUSY  = 1;
  localparam int ST_INIT   = 2;
  localparam int ST_CH_LSB = 4;
  localparam int ST_ER_LSB = 8;
  localparam int SC_LO_LSB = 0;
  localparam int SC_HI_LSB = 4;

  // ==========================================================
  // function numbers and result codes
  localparam logic signed [15:0] F_INIT = 16'sh0000;
  localparam logic signed [15:0] F_ACQ  = 16'sh0004;
  localparam logic signed [15:0] F_TRIG = 16'sh0005;
  localparam logic signed [15:0] F_MAX  = 16'sh0009;
  localparam logic [7:0] E_OK     = 8'h00;
  localparam logic [7:0] E_NOINIT = 8'h01;
  localparam logic [7:0] E_FUNC   = 8'h02;
  localparam logic [7:0] E_FORCE  = 8'h05;
  localparam logic [7:0] E_TCH    = 8'h0a;
  localparam logic [7:0] E_TLVL   = 8'h0b;
  localparam logic [7:0] E_EN     = 8'h0c;
  localparam logic [7:0] E_CYC    = 8'h0d;

  // ==========================================================
  // reset values, limits and timing
  localparam logic [2:0]  SCAN_LO_RST = 3'h0;
  localparam logic [2:0]  SCAN_HI_RST = 3'h7;
  localparam logic [16:0] CNT_FULL    = 17'h10000;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_MHZ    = 200;
  localparam int GATE_US    = 100;
  localparam int GATE_CYC   = GATE_US * CLK_MHZ;

  // ==========================================================
  // types
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_GATE  = 7'h02,
    S_ARMED = 7'h04,
    S_CONV  = 7'h08,
    S_PUSH  = 7'h10,
    S_TWAIT = 7'h20,
    S_TCONV = 7'h40
  } tas_state_t;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] off;
    logic [7:0]  data;
  } tas_word_t;

  typedef struct packed {
    tas_state_t  state;
    logic        trig_q;
    logic [15:0] gate_cnt;
    logic        init;
    logic [2:0]  irq_lvl;
    logic [7:0]  err;
    logic        active;
    logic        cycle;
    logic [15:0] base;
    logic [16:0] n;
    logic [16:0] rem;
    logic [15:0] off;
    logic [2:0]  ch;
    logic [2:0]  lo;
    logic [2:0]  hi;
    logic [2:0]  mux;
    logic [2:0]  tch;
    logic [7:0]  tlvl;
    logic        tslope;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [15:0] p3;
    logic        adc_start;
    logic [7:0]  sample;
    logic [31:0] prdata;
  } tas_st_t;

endpackage

// [hdl/tas_sequencer.sv]
// capture fifo and triggered acquisition sequencer top
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps

// ============================================================
// capture fifo
module tas_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } tas_fifo_st_t;

  tas_fifo_st_t s_r;
  tas_fifo_st_t s_nxt;
  logic         full;
  logic         empty;

  assign empty = s_r.wp == s_r.rp;
  assign full  = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid_i && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
      s_nxt.wp = s_r.wp + {{AW{1'b0}}, 1'b1};
    end
    if (out_ready_i && !empty) begin
      s_nxt.rp = s_r.rp + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ============================================================
// sequencer top
// Functional notes
// - trigger edge converts, stores, advances channel
// - buffer in one fixed 64K region
// - single cycle stops at N, clears active
// - recycle wraps buffer, stays active
// - count is unsigned sixteen bits
// - enable one arms, zero aborts
// - scan limits, default channels zero to seven
// - gate low ignores triggers, 100us arms
// - force start bypasses gate, code five
// - bad enable 12, bad cycle 13
// - codes: ok 0, uninit 1, range 2
// - on completion mask and release irq
// - analog trigger level compare by slope
// - trigger setup errors 10, 11, 12
// - abort request ends trigger wait, code five
// - trigger channel independent of scan range
// - one byte per conversion in sequence
module tas_sequencer #(
  parameter int GATE_CYCLES = tas_pkg::GATE_CYC
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        TRIG_I,
  input  wire logic        START_GATE_INPUT_I,
  input  wire logic        KEY_I,
  output logic             ADC_START_O,
  input  wire logic        ADC_DONE_I,
  input  wire logic [7:0]  ADC_DATA_I,
  output logic [2:0]       MUX_CH_O,
  output logic             MEM_VALID_O,
  input  wire logic        MEM_READY_I,
  output logic [31:0]      MEM_ADDR_O,
  output logic [7:0]       MEM_DATA_O,
  output logic             IRQ_O,
  output logic             IRQ_OE_O,
  output logic             IRQ_MASK_O,
  output logic [2:0]       IRQ_LEVEL_O
);

  tas_pkg::tas_st_t   s_r;
  tas_pkg::tas_st_t   s_nxt;
  tas_pkg::tas_word_t fifo_in;
  tas_pkg::tas_word_t fifo_out;
  logic               push;
  logic               push_rdy;
  logic               rise;
  logic               cmd_wr;
  logic               mapped;
  logic signed [15:0] fn;

  function automatic logic is_bit(input logic [15:0] p);
    is_bit = (p == 16'h0000) || (p == 16'h0001);
  endfunction

  function automatic logic [2:0] next_ch(input logic [2:0] c, input logic [2:0] lo,
                                         input logic [2:0] hi);
    next_ch = (c == hi) ? lo : c + 3'h1;
  endfunction

  // ==========================================================
  // bus decode
  assign mapped = (PADDR_I[7:5] == 3'h0) && (PADDR_I[1:0] == 2'h0);
  assign cmd_wr = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == tas_pkg::A_CMD)
                  && !(s_r.state inside {tas_pkg::S_TWAIT, tas_pkg::S_TCONV});
  assign fn = PWDATA_I[15:0];
  assign rise = TRIG_I && !s_r.trig_q;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O = s_r.prdata;

  // ==========================================================
  // capture buffer path
  assign fifo_in.base = s_r.base;
  assign fifo_in.off = s_r.off;
  assign fifo_in.data = s_r.sample;
  assign push = s_r.state == tas_pkg::S_PUSH;

  tas_fifo #(
    .W ($bits(tas_pkg::tas_word_t)),
    .D (tas_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rstn_i      (RSTN_I),
    .in_valid_i  (push),
    .in_ready_o  (push_rdy),
    .in_data_i   (fifo_in),
    .out_valid_o (MEM_VALID_O),
    .out_ready_i (MEM_READY_I),
    .out_data_o  (fifo_out)
  );

  assign MEM_ADDR_O = {fifo_out.base, fifo_out.off};
  assign MEM_DATA_O = fifo_out.data;
  assign ADC_START_O = s_r.adc_start;
  assign MUX_CH_O = s_r.mux;
  assign IRQ_O = s_r.trig_q && s_r.active;
  assign IRQ_OE_O = s_r.active;
  assign IRQ_MASK_O = !s_r.active;
  assign IRQ_LEVEL_O = s_r.irq_lvl;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.adc_start = 1'b0;
    s_nxt.trig_q = TRIG_I;
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      s_nxt.prdata = 32'h0;
      case (PADDR_I)
        tas_pkg::A_P0: s_nxt.prdata[15:0] = s_r.p0;
        tas_pkg::A_P1: s_nxt.prdata[15:0] = s_r.p1;
        tas_pkg::A_P2: s_nxt.prdata[15:0] = s_r.p2;
        tas_pkg::A_P3: s_nxt.prdata[15:0] = s_r.p3;
        tas_pkg::A_STAT: begin
          s_nxt.prdata[tas_pkg::ST_ACTIVE] = s_r.active;
          s_nxt.prdata[tas_pkg::ST_TBUSY] = s_r.state[5] | s_r.state[6];
          s_nxt.prdata[tas_pkg::ST_INIT] = s_r.init;
          s_nxt.prdata[tas_pkg::ST_CH_LSB +: 3] = s_r.ch;
          s_nxt.prdata[tas_pkg::ST_ER_LSB +: 8] = s_r.err;
        end
        tas_pkg::A_REM: s_nxt.prdata[16:0] = s_r.active ? s_r.rem : 17'h0;
        tas_pkg::A_SCAN: begin
          s_nxt.prdata[tas_pkg::SC_LO_LSB +: 3] = s_r.lo;
          s_nxt.prdata[tas_pkg::SC_HI_LSB +: 3] = s_r.hi;
        end
        default: s_nxt.prdata = 32'h0;
      endcase
    end
    case (s_r.state)
      tas_pkg::S_GATE: begin
        if (KEY_I) begin
          s_nxt.err = tas_pkg::E_FORCE;
          s_nxt.state = tas_pkg::S_ARMED;
        end else if (!START_GATE_INPUT_I) begin
          s_nxt.gate_cnt = 16'h0;
        end else if (s_r.gate_cnt == 16'(GATE_CYCLES - 1)) begin
          s_nxt.state = tas_pkg::S_ARMED;
        end else begin
          s_nxt.gate_cnt = s_r.gate_cnt + 16'h1;
        end
      end
      tas_pkg::S_ARMED: begin
        if (rise) begin
          s_nxt.adc_start = 1'b1;
          s_nxt.mux = s_r.ch;
          s_nxt.state = tas_pkg::S_CONV;
        end
      end
      tas_pkg::S_CONV: begin
        if (ADC_DONE_I) begin
          s_nxt.sample = ADC_DATA_I;
          s_nxt.state = tas_pkg::S_PUSH;
        end
      end
      tas_pkg::S_PUSH: begin
        if (push_rdy) begin
          s_nxt.ch = next_ch(s_r.ch, s_r.lo, s_r.hi);
          s_nxt.state = tas_pkg::S_ARMED;
          if (s_r.rem != 17'h1) begin
            s_nxt.rem = s_r.rem - 17'h1;
            s_nxt.off = s_r.off + 16'h1;
          end else if (s_r.cycle) begin
            s_nxt.rem = s_r.n;
            s_nxt.off = 16'h0;
          end else begin
            s_nxt.active = 1'b0;
            s_nxt.state = tas_pkg::S_IDLE;
          end
        end
      end
      tas_pkg::S_TWAIT: begin
        if (KEY_I) begin
          s_nxt.err = tas_pkg::E_FORCE;
          s_nxt.state = tas_pkg::S_IDLE;
        end else begin
          s_nxt.adc_start = 1'b1;
          s_nxt.mux = s_r.tch;
          s_nxt.state = tas_pkg::S_TCONV;
        end
      end
      tas_pkg::S_TCONV: begin
        if (KEY_I) begin
          s_nxt.err = tas_pkg::E_FORCE;
          s_nxt.state = tas_pkg::S_IDLE;
        end else if (ADC_DONE_I) begin
          if (s_r.tslope ? ($signed(ADC_DATA_I) < $signed(s_r.tlvl))
                         : ($signed(ADC_DATA_I) > $signed(s_r.tlvl))) begin
            s_nxt.state = tas_pkg::S_IDLE;
          end else begin
            s_nxt.state = tas_pkg::S_TWAIT;
          end
        end
      end
      default: s_nxt.state = tas_pkg::S_IDLE;
    endcase
    if (PSEL_I && PENABLE_I && PWRITE_I) begin
      case (PADDR_I)
        tas_pkg::A_P0: s_nxt.p0 = PWDATA_I[15:0];
        tas_pkg::A_P1: s_nxt.p1 = PWDATA_I[15:0];
        tas_pkg::A_P2: s_nxt.p2 = PWDATA_I[15:0];
        tas_pkg::A_P3: s_nxt.p3 = PWDATA_I[15:0];
        tas_pkg::A_SCAN: begin
          s_nxt.lo = PWDATA_I[tas_pkg::SC_LO_LSB +: 3];
          s_nxt.hi = PWDATA_I[tas_pkg::SC_HI_LSB +: 3];
        end
        default: s_nxt.p0 = s_nxt.p0;
      endcase
    end
    if (cmd_wr) begin
      s_nxt.err = tas_pkg::E_OK;
      if (fn < tas_pkg::F_INIT || fn > tas_pkg::F_MAX) begin
        s_nxt.err = tas_pkg::E_FUNC;
      end else if (!s_r.init && fn != tas_pkg::F_INIT) begin
        s_nxt.err = tas_pkg::E_NOINIT;
      end else if (fn == tas_pkg::F_INIT) begin
        s_nxt.init = 1'b1;
        s_nxt.irq_lvl = s_r.p0[2:0];
        s_nxt.active = 1'b0;
        s_nxt.state = tas_pkg::S_IDLE;
      end else if (fn == tas_pkg::F_ACQ) begin
        if (!is_bit(s_r.p2)) begin
          s_nxt.err = tas_pkg::E_EN;
        end else if (!is_bit(s_r.p3)) begin
          s_nxt.err = tas_pkg::E_CYC;
        end else if (!s_r.p2[0]) begin
          s_nxt.active = 1'b0;
          s_nxt.state = tas_pkg::S_IDLE;
        end else begin
          s_nxt.n = (s_r.p0 == 16'h0) ? tas_pkg::CNT_FULL : {1'b0, s_r.p0};
          s_nxt.rem = (s_r.p0 == 16'h0) ? tas_pkg::CNT_FULL : {1'b0, s_r.p0};
          s_nxt.base = s_r.p1;
          s_nxt.cycle = s_r.p3[0];
          s_nxt.off = 16'h0;
          s_nxt.ch = s_r.lo;
          s_nxt.gate_cnt = 16'h0;
          s_nxt.active = 1'b1;
          s_nxt.state = tas_pkg::S_GATE;
        end
      end else if (fn == tas_pkg::F_TRIG) begin
        if (s_r.p0[15] || s_r.p0 > 16'h0007) begin
          s_nxt.err = tas_pkg::E_TCH;
        end else if ($signed(s_r.p1) < -16'sd128 || $signed(s_r.p1) > 16'sd127) begin
          s_nxt.err = tas_pkg::E_TLVL;
        end else if (!is_bit(s_r.p2)) begin
          s_nxt.err = tas_pkg::E_EN;
        end else begin
          s_nxt.tch = s_r.p0[2:0];
          s_nxt.tlvl = s_r.p1[7:0];
          s_nxt.tslope = s_r.p2[0];
          s_nxt.active = 1'b0;
          s_nxt.state = tas_pkg::S_TWAIT;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '0;
      s_r.state <= tas_pkg::S_IDLE;
      s_r.lo <= tas_pkg::SCAN_LO_RST;
      s_r.hi <= tas_pkg::SCAN_HI_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_trig_conv;
    s_r.state == tas_pkg::S_ARMED && rise && !cmd_wr
      |=> ADC_START_O && MUX_CH_O == $past(s_r.ch) ##1 !ADC_START_O;
  endproperty
  a_trig_conv: assert property (p_trig_conv) else $error("no conversion on trigger");

  property p_ch_adv;
    s_r.state == tas_pkg::S_PUSH && push_rdy && !cmd_wr
      |=> s_r.ch == (($past(s_r.ch) == $past(s_r.hi)) ? $past(s_r.lo) : $past(s_r.ch) + 3'h1);
  endproperty
  a_ch_adv: assert property (p_ch_adv) else $error("channel did not advance");

  property p_single_end;
    s_r.state == tas_pkg::S_PUSH && push_rdy && s_r.rem == 17'h1 && !s_r.cycle && !cmd_wr
      |=> !s_r.active && s_r.state == tas_pkg::S_IDLE && IRQ_MASK_O && !IRQ_OE_O;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single cycle did not stop");

  property p_recycle;
    s_r.state == tas_pkg::S_PUSH && push_rdy && s_r.rem == 17'h1 && s_r.cycle && !cmd_wr
      |=> s_r.active && s_r.off == 16'h0 && s_r.rem == s_r.n;
  endproperty
  a_recycle: assert property (p_recycle) else $error("recycle did not reload");

  property p_byte_step;
    s_r.state == tas_pkg::S_PUSH && push_rdy && s_r.rem != 17'h1 && !cmd_wr
      |=> s_r.off == $past(s_r.off) + 16'h1 && s_r.rem == $past(s_r.rem) - 17'h1;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("offset step wrong");

  property p_gate_low;
    s_r.state == tas_pkg::S_GATE && !START_GATE_INPUT_I && !KEY_I
      |=> s_r.state != tas_pkg::S_ARMED;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("armed with gate low");

  property p_force;
    s_r.state == tas_pkg::S_GATE && KEY_I && !cmd_wr
      |=> s_r.err == tas_pkg::E_FORCE && s_r.state == tas_pkg::S_ARMED;
  endproperty
  a_force: assert property (p_force) else $error("force start not reported");

  property p_fn_range;
    cmd_wr && fn > tas_pkg::F_MAX |=> s_r.err == tas_pkg::E_FUNC;
  endproperty
  a_fn_range: assert property (p_fn_range) else $error("function range not rejected");

  property p_bad_en;
    cmd_wr && fn == tas_pkg::F_ACQ && s_r.init && s_r.p2 > 16'h0001
      |=> s_r.err == tas_pkg::E_EN && $stable(s_r.active);
  endproperty
  a_bad_en: assert property (p_bad_en) else $error("bad enable not rejected");

  property p_pos_slope;
    s_r.state == tas_pkg::S_TCONV && ADC_DONE_I && !KEY_I && !s_r.tslope
      && $signed(ADC_DATA_I) > $signed(s_r.tlvl) |=> s_r.state == tas_pkg::S_IDLE;
  endproperty
  a_pos_slope: assert property (p_pos_slope) else $error("positive slope missed");

  property p_trig_abort;
    s_r.state inside {tas_pkg::S_TWAIT, tas_pkg::S_TCONV} && KEY_I
      |=> s_r.err == tas_pkg::E_FORCE && s_r.state == tas_pkg::S_IDLE;
  endproperty
  a_trig_abort: assert property (p_trig_abort) else $error("trigger wait not aborted");

  c_single: cover property (s_r.active ##1 !s_r.active && s_r.state == tas_pkg::S_IDLE);
  c_recycle: cover property (s_r.state == tas_pkg::S_PUSH && s_r.rem == 17'h1 && s_r.cycle);
  c_fifo_full: cover property (s_r.state == tas_pkg::S_PUSH && !push_rdy);
  c_atrig: cover property (s_r.state == tas_pkg::S_TCONV ##1 s_r.state == tas_pkg::S_IDLE);
endmodule

// [bench/tas_conv_model.sv]
// converter model answering start pulses after a chosen latency
`timescale 1ns/1ps
module tas_conv_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       start_i,
  input  wire logic [7:0] smp_i,
  input  wire logic [2:0] lat_i,
  output logic            done_o,
  output logic [7:0]      data_o
);
  // ==================
  // conversion timer, data invalid outside done
  logic [3:0] cnt_r;
  logic [7:0] last_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= 4'h0;
      last_r <= 8'h0;
      done_o <= 1'b0;
      data_o <= 8'h0;
    end else begin
      done_o <= 1'b0;
      data_o <= ~last_r;
      if (start_i)
        cnt_r <= {1'b0, lat_i} + 4'h1;
      else if (cnt_r == 4'h1) begin
        cnt_r  <= 4'h0;
        done_o <= 1'b1;
        data_o <= smp_i;
        last_r <= smp_i;
      end else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// [bench/tas_sequencer_tb.sv]
// self-checking bench of the triggered acquisition sequencer
`timescale 1ns/1ps
module tas_sequencer_tb;
  // ==================
  // signals
  localparam int GC = 20;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        trig = 1'b0, gate = 1'b0, key = 1'b0, rdy = 1'b0, hold_rdy = 1'b1;
  logic        pready, perr, pslverr, adc_start, adc_done, mem_valid, irq_oe, irq_mask, irq;
  logic        cyc_mode;
  logic [2:0]  lat = 3'h0, mux, irq_lvl, ch, lo, hi;
  logic [7:0]  paddr = 8'h0, smp = 8'h0, adc_data, mem_data;
  logic [15:0] base, off, n;
  logic [31:0] pwdata = 32'h0, prdata, st, mem_addr;
  logic [39:0] q[$];
  int          n_errors = 0, checks = 0, cyc = 0;

  always #2.5 clk = ~clk;

  tas_sequencer #(.GATE_CYCLES(GC)) dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TRIG_I(trig), .START_GATE_INPUT_I(gate), .KEY_I(key),
    .ADC_START_O(adc_start), .ADC_DONE_I(adc_done), .ADC_DATA_I(adc_data), .MUX_CH_O(mux),
    .MEM_VALID_O(mem_valid), .MEM_READY_I(rdy), .MEM_ADDR_O(mem_addr),
    .MEM_DATA_O(mem_data), .IRQ_O(irq), .IRQ_OE_O(irq_oe), .IRQ_MASK_O(irq_mask),
    .IRQ_LEVEL_O(irq_lvl)
  );

  tas_conv_model conv (
    .clk_i(clk), .rstn_i(rstn), .start_i(adc_start), .smp_i(smp), .lat_i(lat),
    .done_o(adc_done), .data_o(adc_data)
  );

  // ==================
  // reporting
  task automatic test_done;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_o, output logic er);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd_o = prdata;
    er   = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x, perr);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d, perr);
  endtask

  task automatic cmdc(input logic [15:0] fn, p0, p1, p2, p3, input logic [7:0] code);
    wr(tas_pkg::A_P0, {16'h0, p0});
    wr(tas_pkg::A_P1, {16'h0, p1});
    wr(tas_pkg::A_P2, {16'h0, p2});
    wr(tas_pkg::A_P3, {16'h0, p3});
    wr(tas_pkg::A_CMD, {16'h0, fn});
    rd(tas_pkg::A_STAT, st);
    chk({56'h0, code}, {56'h0, st[15:8]});
  endtask

  task automatic stat(input logic [7:0] code, input logic act, busy);
    rd(tas_pkg::A_STAT, st);
    chk({56'h0, code}, {56'h0, st[15:8]});
    chk({62'h0, act, busy}, {62'h0, st[tas_pkg::ST_ACTIVE], st[tas_pkg::ST_TBUSY]});
  endtask

  task automatic acq(input logic [15:0] cnt, b, en, cy, input logic [7:0] code);
    base     = b;
    n        = cnt;
    off      = 16'h0;
    ch       = lo;
    cyc_mode = cy[0];
    cmdc(tas_pkg::F_ACQ, cnt, b, en, cy, code);
  endtask

  task automatic press;
    key <= 1'b1;
    repeat (3) @(posedge clk);
    key <= 1'b0;
    @(posedge clk);
  endtask

  // ==================
  // trigger one edge, note the expected word
  task automatic trig_one(input logic exp_conv);
    logic [7:0] d;
    logic       seen;
    d = 8'($urandom);
    seen = 1'b0;
    smp  <= d;
    trig <= 1'b1;
    for (int k = 0; k < 30 && !seen; k++) begin
      @(posedge clk);
      seen = (adc_start === 1'b1);
    end
    trig <= 1'b0;
    chk({63'h0, exp_conv}, {63'h0, seen});
    if (seen) begin
      chk({61'h0, ch}, {61'h0, mux});
      chk(64'h1, {63'h0, irq});
      q.push_back({base, off, d});
      off = (cyc_mode && off + 16'h1 == n) ? 16'h0 : off + 16'h1;
      ch  = (ch == hi) ? lo : ch + 3'h1;
    end
    repeat (12) @(posedge clk);
  endtask

  task automatic drain;
    for (int k = 0; k < 300 && q.size() > 0; k++)
      @(posedge clk);
    chk(64'h0, 64'(q.size()));
  endtask

  // ==================
  // memory side, random stalls, timeout
  always @(posedge clk) begin
    rdy <= hold_rdy ? 1'b0 : 1'($urandom);
    lat <= 3'($urandom_range(4, 0));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  always @(posedge clk) begin
    if (mem_valid === 1'b1 && rdy === 1'b1) begin
      if (q.size() == 0)
        q.push_back(40'hffffffffff);
      chk({24'h0, q.pop_front()}, {24'h0, mem_addr, mem_data});
    end
  end

  // ==================
  // main sequence
  initial begin
    void'($urandom(91));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    lo = 3'h0;
    hi = 3'h7;
    chk(64'h1, {63'h0, irq_mask});
    rd(tas_pkg::A_SCAN, st);
    chk(64'h70, {32'h0, st});
    apb(1'b0, 8'h20, 32'h0, st, perr);
    chk(64'h1, {63'h0, perr});
    cmdc(tas_pkg::F_ACQ, 16'h0, 16'h0, 16'h0, 16'h0, tas_pkg::E_NOINIT);
    cmdc(tas_pkg::F_INIT, 16'h3, 16'h0, 16'h0, 16'h0, tas_pkg::E_OK);
    chk(64'h3, {61'h0, irq_lvl});
    cmdc(16'ha, 16'h0, 16'h0, 16'h0, 16'h0, tas_pkg::E_FUNC);
    cmdc(16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, tas_pkg::E_FUNC);
    cmdc(16'h7, 16'h0, 16'h0, 16'h0, 16'h0, tas_pkg::E_OK);
    acq(16'h9, 16'h1, 16'h2, 16'h0, tas_pkg::E_EN);
    acq(16'h9, 16'h1, 16'h1, 16'h2, tas_pkg::E_CYC);
    // single run, default scan, memory stalled until full
    acq(16'h9, 16'($urandom), 16'h1, 16'h0, tas_pkg::E_OK);
    trig_one(1'b0);
    gate <= 1'b1;
    repeat (GC - 5) @(posedge clk);
    gate <= 1'b0;
    trig_one(1'b0);
    gate <= 1'b1;
    repeat (GC + 3) @(posedge clk);
    gate <= 1'b0;
    stat(tas_pkg::E_OK, 1'b1, 1'b0);
    chk(64'h2, {62'h0, irq_oe, irq_mask});
    for (int i = 0; i < 9; i++)
      trig_one(1'b1);
    hold_rdy <= 1'b0;
    drain();
    stat(tas_pkg::E_OK, 1'b0, 1'b0);
    chk(64'h1, {62'h0, irq_oe, irq_mask});
    trig_one(1'b0);
    // recycle run over narrowed scan
    wr(tas_pkg::A_SCAN, 32'h32);
    lo = 3'h2;
    hi = 3'h3;
    gate <= 1'b1;
    acq(16'h2, 16'($urandom), 16'h1, 16'h1, tas_pkg::E_OK);
    repeat (GC + 3) @(posedge clk);
    for (int i = 0; i < 5; i++)
      trig_one(1'b1);
    stat(tas_pkg::E_OK, 1'b1, 1'b0);
    cmdc(tas_pkg::F_ACQ, 16'h2, 16'h0, 16'h0, 16'h1, tas_pkg::E_OK);
    stat(tas_pkg::E_OK, 1'b0, 1'b0);
    trig_one(1'b0);
    drain();
    gate <= 1'b0;
    // forced start with gate low
    acq(16'h4, 16'($urandom), 16'h1, 16'h0, tas_pkg::E_OK);
    press();
    stat(tas_pkg::E_FORCE, 1'b1, 1'b0);
    trig_one(1'b1);
    cmdc(tas_pkg::F_ACQ, 16'h4, 16'h0, 16'h0, 16'h0, tas_pkg::E_OK);
    drain();
    for (int i = 0; i < 2; i++) begin
      acq(i ? 16'h0 : 16'hffff, 16'h0, 16'h1, 16'h0, tas_pkg::E_OK);
      press();
      rd(tas_pkg::A_REM, st);
      chk(i ? 64'h10000 : 64'hffff, {47'h0, st[16:0]});
      cmdc(tas_pkg::F_ACQ, 16'h1, 16'h0, 16'h0, 16'h0, tas_pkg::E_OK);
    end
    // analog trigger
    cmdc(tas_pkg::F_TRIG, 16'h8, 16'h0, 16'h0, 16'h0, tas_pkg::E_TCH);
    cmdc(tas_pkg::F_TRIG, 16'h6, 16'h0080, 16'h0, 16'h0, tas_pkg::E_TLVL);
    cmdc(tas_pkg::F_TRIG, 16'h6, 16'hff7f, 16'h0, 16'h0, tas_pkg::E_TLVL);
    cmdc(tas_pkg::F_TRIG, 16'h6, 16'h000a, 16'h2, 16'h0, tas_pkg::E_EN);
    for (int s = 0; s < 2; s++) begin
      smp <= 8'h0a;
      cmdc(tas_pkg::F_TRIG, 16'h6, 16'h000a, 16'(s), 16'h0, tas_pkg::E_OK);
      repeat (30) @(posedge clk);
      stat(tas_pkg::E_OK, 1'b0, 1'b1);
      chk(64'h6, {61'h0, mux});
      smp <= s ? 8'h09 : 8'h0b;
      repeat (30) @(posedge clk);
      stat(tas_pkg::E_OK, 1'b0, 1'b0);
    end
    smp <= 8'h0a;
    cmdc(tas_pkg::F_TRIG, 16'h6, 16'h000a, 16'h0, 16'h0, tas_pkg::E_OK);
    repeat (10) @(posedge clk);
    press();
    repeat (5) @(posedge clk);
    stat(tas_pkg::E_FORCE, 1'b0, 1'b0);
    test_done();
  end
endmodule
